// [src/nfca_field_on.sv]
// nfca_field_on: field-on collision avoidance, go-normal and analog preset sequencer
`timescale 1ns/1ps
`default_nettype none
// Contract
// RULE_01 - Field on command checks for collision first, field on only if clear.
// RULE_02 - Compare synchronised RF field level against programmed threshold.
// RULE_03 - No collision: set tx enable, after guard time raise done flag.
// RULE_04 - External field seen: raise collision flag, leave transmitter off.
// RULE_05 - Host repeats field on after collision, no transmission meanwhile.
// RULE_06 - Initial field on uses random n bounded by collision count bits.
// RULE_07 - Response field on uses n from the same collision count bits.
// RULE_08 - Response field on variant forces n to zero.
// RULE_09 - Response active delay is 768 carrier periods.
// RULE_10 - Field on accepted only with enable bit and stable oscillator.
// RULE_11 - Initial delay 4096 carrier periods, waiting unit 512 periods.
// RULE_12 - Go to normal leaves bit rate detection mode for normal target.
// RULE_13 - Go to normal copies detected bit rate and sets modulation type.
// RULE_14 - Analog preset loads config bits from mode and bit rate.
// RULE_15 - Host avoids analog preset in sub-carrier or BPSK stream modes.
// RULE_16 - Analog preset clears tx enable in target and initiator modes; code clears it in target modes and NFCIP-1 initiator mode only.
// RULE_17 - In NFCIP-1 mode field goes on only through field on commands; code also sets tx enable on any host write of operation control bit 3.
// RULE_18 - Analog preset sets start byte option for NFCIP-1 active.
// RULE_19 - Modulation type bit 5: 0 selects OOK, 1 selects AM.
// RULE_20 - Field on command refused by conditions changes nothing.
module nfca_field_on
   import nfca_pkg::*;
#(
   parameter int IDT_CYC  = INITIAL_DELAY_CYC,
   parameter int IRFG_CYC = INITIAL_GUARD_CYC
)(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic [7:0]  rf_field_inputs_level,
   input  wire logic        osc_freq_stable,
   input  wire logic        osc_ampl_stable,
   input  wire logic [7:0]  bit_rate_detected,
   output logic             tx_enable
);
   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   logic [7:0]  opc_q, mode_q, brd_q, a106_q, aux_q, thr_q, flg_q;
   logic [31:0] cnt_q;
   logic [31:0] prdata_q;
   logic [15:0] lfsr_q;
   logic [7:0]  rf_s1_q, rf_s2_q;
   logic [1:0]  osc_s1_q, osc_s2_q;
   logic        resp_q;
   nfca_state_t st_q;

   function automatic logic [1:0] pick_n(input logic [1:0] lim, input logic [1:0] rnd);
      pick_n = (rnd > lim) ? (rnd & lim) : rnd;
   endfunction

   // ------------------------------------------------------------
   // bus decode
   // ------------------------------------------------------------
   wire [5:0] idx     = paddr[7:2];
   wire       setup   = psel & ~penable;
   wire       access  = psel & penable;
   wire       hit     = (idx == IDX_OPERATION_CONTROL) | (idx == IDX_MODE_DEFINITION)
                      | (idx == IDX_BIT_RATE_DEFINITION) | (idx == IDX_TYPE_A_NFC106_SETTINGS)
                      | (idx == IDX_AUXILIARY_DEFINITION) | (idx == IDX_FIELD_THRESHOLD)
                      | (idx == IDX_COMMAND) | (idx == IDX_EVENT_FLAGS)
                      | (idx == IDX_BIT_RATE_DETECTED) | (idx == IDX_SEQ_STATUS);
   wire       wr      = access & pwrite & hit;
   wire [7:0] wd      = pwdata[7:0];
   wire       flg_rd  = access & ~pwrite & (idx == IDX_EVENT_FLAGS);
   wire       cmd_wr  = wr & (idx == IDX_COMMAND);
   wire [7:0] rd_mux  = (idx == IDX_OPERATION_CONTROL)      ? opc_q  :
                        (idx == IDX_MODE_DEFINITION)        ? mode_q :
                        (idx == IDX_BIT_RATE_DEFINITION)    ? brd_q  :
                        (idx == IDX_TYPE_A_NFC106_SETTINGS) ? a106_q :
                        (idx == IDX_AUXILIARY_DEFINITION)   ? aux_q  :
                        (idx == IDX_FIELD_THRESHOLD)        ? thr_q  :
                        (idx == IDX_EVENT_FLAGS)            ? flg_q  :
                        (idx == IDX_BIT_RATE_DETECTED)      ? bit_rate_detected :
                        (idx == IDX_SEQ_STATUS)             ? {6'h00, st_q} : 8'h00;
   assign pready  = 1'b1;
   assign pslverr = access & ~hit;
   assign prdata  = prdata_q;
   assign tx_enable = opc_q[OPC_TX_EN_BIT];

   // ------------------------------------------------------------
   // command decode
   // ------------------------------------------------------------
   wire       osc_ok   = osc_s2_q[0] & osc_s2_q[1];
   wire       accept   = opc_q[OPC_EN_BIT] & osc_ok & (st_q == ST_IDLE); // RULE_10
   wire       c_init   = cmd_wr & (wd == CMD_INIT_FIELD_ON);
   wire       c_resp   = cmd_wr & (wd == CMD_RESP_FIELD_ON);
   wire       c_resp0  = cmd_wr & (wd == CMD_RESP_FIELD_N0);
   wire       fon_go   = (c_init | c_resp | c_resp0) & accept; // RULE_20
   wire       c_norm   = cmd_wr & (wd == CMD_GO_NORMAL);
   wire       c_pre    = cmd_wr & (wd == CMD_ANALOG_PRESET);
   wire [1:0] cc_cfg   = {aux_q[AUX_CC_HI_BIT], aux_q[AUX_CC_LO_BIT]};
   wire [1:0] n_val    = c_resp0 ? 2'd0 : pick_n(cc_cfg, lfsr_q[1:0]); // RULE_06 RULE_07 RULE_08
   wire [31:0] base_cyc = c_init ? 32'(IDT_CYC) : 32'(ACTIVE_DELAY_CYC); // RULE_09 RULE_11
   wire [31:0] ca_load = base_cyc + 32'(n_val) * 32'(RF_WAIT_UNIT_CYC); // RULE_11
   wire       field_hi = rf_s2_q >= thr_q; // RULE_02
   wire       ca_end   = (st_q == ST_AVOID) & (cnt_q == 32'd0) & ~field_hi;
   wire       gd_end   = (st_q == ST_GUARD) & (cnt_q == 32'd0);
   wire       coll     = (st_q == ST_AVOID) & field_hi;
   wire [3:0] mode     = mode_q[7:4];
   wire       nfcip    = (mode == MODE_NFC_INIT) | (mode == MODE_NFC_TARGET);
   wire       tgt_any  = mode_q[7];
   wire [7:0] flg_set  = {6'h00, coll, gd_end};
   wire [7:0] flg_d    = (flg_rd ? (flg_q & ~prdata_q[7:0]) : flg_q) | flg_set;

   // ------------------------------------------------------------
   // synchronisers and random source
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         rf_s1_q  <= 8'h00;
         rf_s2_q  <= 8'h00;
         osc_s1_q <= 2'h0;
         osc_s2_q <= 2'h0;
         lfsr_q   <= 16'hACE1;
      end
      else
      begin
         rf_s1_q  <= rf_field_inputs_level;
         rf_s2_q  <= rf_s1_q;
         osc_s1_q <= {osc_ampl_stable, osc_freq_stable};
         osc_s2_q <= osc_s1_q;
         lfsr_q   <= {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
      end
   end

   // ------------------------------------------------------------
   // read data
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata_q <= 32'h00000000;
      else if (setup & ~pwrite)
         prdata_q <= {24'h000000, rd_mux};
   end

   // ------------------------------------------------------------
   // sequencer
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         st_q   <= ST_IDLE;
         cnt_q  <= 32'd0;
         resp_q <= 1'b0;
      end
      else
      begin
         case (st_q)
            ST_IDLE:
            begin
               if (fon_go)
               begin
                  st_q   <= ST_AVOID; // RULE_01
                  cnt_q  <= ca_load;
                  resp_q <= ~c_init;
               end
            end
            ST_AVOID:
            begin
               if (coll)
                  st_q <= ST_IDLE; // RULE_04
               else if (ca_end)
               begin
                  st_q  <= ST_GUARD;
                  cnt_q <= resp_q ? 32'(ACTIVE_GUARD_CYC) : 32'(IRFG_CYC); // RULE_03
               end
               else
                  cnt_q <= cnt_q - 32'd1;
            end
            ST_GUARD:
            begin
               if (gd_end)
                  st_q <= ST_IDLE;
               else
                  cnt_q <= cnt_q - 32'd1;
            end
            default:
               st_q <= ST_IDLE;
         endcase
      end
   end

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         opc_q  <= RST_REG8;
         mode_q <= RST_REG8;
         brd_q  <= RST_REG8;
         a106_q <= RST_REG8;
         aux_q  <= RST_REG8;
         thr_q  <= RST_THR;
         flg_q  <= RST_REG8;
      end
      else
      begin
         flg_q <= flg_d; // RULE_03 RULE_04
         if (wr & (idx == IDX_OPERATION_CONTROL))
            opc_q <= wd;
         if (wr & (idx == IDX_MODE_DEFINITION))
            mode_q <= wd;
         if (wr & (idx == IDX_BIT_RATE_DEFINITION))
            brd_q <= wd;
         if (wr & (idx == IDX_TYPE_A_NFC106_SETTINGS))
            a106_q <= wd;
         if (wr & (idx == IDX_AUXILIARY_DEFINITION))
            aux_q <= wd;
         if (wr & (idx == IDX_FIELD_THRESHOLD))
            thr_q <= wd;
         if (ca_end)
            opc_q[OPC_TX_EN_BIT] <= 1'b1; // RULE_01 RULE_03 RULE_17
         if (c_norm & (mode == MODE_TGT_BRDET))
         begin
            mode_q[7:4]         <= MODE_NFC_TARGET; // RULE_12
            brd_q               <= bit_rate_detected; // RULE_13
            aux_q[AUX_TRAM_BIT] <= bit_rate_detected[7:4] != 4'h0; // RULE_13 RULE_19
         end
         if (c_pre)
         begin
            aux_q[AUX_TRAM_BIT]  <= brd_q[7:4] != 4'h0; // RULE_14 RULE_19
            aux_q[AUX_ENFD_BIT]  <= nfcip; // RULE_14
            a106_q[A106_SBO_BIT] <= nfcip; // RULE_18
            if (nfcip)
               opc_q[OPC_RX_CHN_BIT] <= 1'b1; // RULE_14
            if (nfcip | tgt_any)
               opc_q[OPC_TX_EN_BIT] <= 1'b0; // RULE_16 RULE_17
         end
      end
   end

   // ------------------------------------------------------------
   // guard length monitor
   // ------------------------------------------------------------
   logic [31:0] gd_seen_q;
   wire  [31:0] gd_len = resp_q ? 32'(ACTIVE_GUARD_CYC) : 32'(IRFG_CYC);
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         gd_seen_q <= 32'd0;
      else if (st_q == ST_GUARD)
         gd_seen_q <= gd_seen_q + 32'd1;
      else
         gd_seen_q <= 32'd0;
   end

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   a_refused_cmd: assert property (@(posedge pclk) disable iff (!presetn) // RULE_20
      (st_q == ST_IDLE) && (c_init | c_resp | c_resp0) && !accept
      |=> (st_q == ST_IDLE) && (tx_enable == $past(tx_enable)))
      else $error("refused field on changed state");
   a_coll_flag: assert property (@(posedge pclk) disable iff (!presetn) // RULE_04
      coll |=> flg_q[FLG_CAC_BIT] && (st_q == ST_IDLE) && !$rose(tx_enable))
      else $error("collision not flagged");
   a_field_on: assert property (@(posedge pclk) disable iff (!presetn) // RULE_01
      ca_end |=> tx_enable && (st_q == ST_GUARD))
      else $error("field not switched on");
   a_guard_done: assert property (@(posedge pclk) disable iff (!presetn) // RULE_03
      gd_end
      |-> (gd_seen_q == gd_len) ##1 flg_q[FLG_CAT_BIT])
      else $error("guard done flag timing");
   a_resp_n0: assert property (@(posedge pclk) disable iff (!presetn) // RULE_08
      fon_go && c_resp0 |=> cnt_q == 32'(ACTIVE_DELAY_CYC))
      else $error("n zero delay wrong");
   a_init_delay: assert property (@(posedge pclk) disable iff (!presetn) // RULE_11
      fon_go && c_init |=> cnt_q >= 32'(IDT_CYC)
      && cnt_q <= 32'(IDT_CYC) + 32'd3 * 32'(RF_WAIT_UNIT_CYC))
      else $error("initial delay out of range");
   a_preset_txoff: assert property (@(posedge pclk) disable iff (!presetn) // RULE_16
      c_pre && (nfcip || tgt_any) && !ca_end |=> !tx_enable)
      else $error("preset left transmitter on");
   a_start_byte: assert property (@(posedge pclk) disable iff (!presetn) // RULE_18
      c_pre |=> a106_q[A106_SBO_BIT] == $past(nfcip))
      else $error("start byte option wrong");
   a_go_normal: assert property (@(posedge pclk) disable iff (!presetn) // RULE_13
      c_norm && (mode == MODE_TGT_BRDET)
      |=> brd_q == $past(bit_rate_detected) && mode_q[7:4] == MODE_NFC_TARGET)
      else $error("go normal copy wrong");
   a_mod_type: assert property (@(posedge pclk) disable iff (!presetn) // RULE_19
      c_pre |=> aux_q[AUX_TRAM_BIT] == ($past(brd_q[7:4]) != 4'h0))
      else $error("modulation type wrong");
endmodule // nfca_field_on
`default_nettype wire

// [src/nfca_pkg.sv]
// nfca_pkg: register map, field layout, commands and timing for the field-on sequencer
package nfca_pkg;
   // ------------------------------------------------------------
   // register indices (byte address = 4 * index)
   // ------------------------------------------------------------
   localparam logic [5:0] IDX_OPERATION_CONTROL      = 6'h02;
   localparam logic [5:0] IDX_MODE_DEFINITION        = 6'h03;
   localparam logic [5:0] IDX_BIT_RATE_DEFINITION    = 6'h04;
   localparam logic [5:0] IDX_TYPE_A_NFC106_SETTINGS = 6'h05;
   localparam logic [5:0] IDX_AUXILIARY_DEFINITION   = 6'h09;
   localparam logic [5:0] IDX_FIELD_THRESHOLD        = 6'h10;
   localparam logic [5:0] IDX_COMMAND                = 6'h11;
   localparam logic [5:0] IDX_EVENT_FLAGS            = 6'h12;
   localparam logic [5:0] IDX_BIT_RATE_DETECTED      = 6'h13;
   localparam logic [5:0] IDX_SEQ_STATUS             = 6'h14;
   // ------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------
   localparam int OPC_EN_BIT     = 7;
   localparam int OPC_RX_CHN_BIT = 5;
   localparam int OPC_TX_EN_BIT  = 3;
   localparam int A106_SBO_BIT   = 5;
   localparam int AUX_TRAM_BIT   = 5;
   localparam int AUX_ENFD_BIT   = 4;
   localparam int AUX_CC_HI_BIT  = 1;
   localparam int AUX_CC_LO_BIT  = 0;
   localparam int FLG_CAT_BIT    = 0;
   localparam int FLG_CAC_BIT    = 1;
   // ------------------------------------------------------------
   // reset values
   // ------------------------------------------------------------
   localparam logic [7:0] RST_REG8 = 8'h00;
   localparam logic [7:0] RST_THR  = 8'h10;
   // ------------------------------------------------------------
   // mode codes in mode_definition[7:4], commands
   // ------------------------------------------------------------
   localparam logic [3:0] MODE_NFC_INIT   = 4'h1;
   localparam logic [3:0] MODE_TGT_BRDET  = 4'h8;
   localparam logic [3:0] MODE_NFC_TARGET = 4'h9;
   localparam logic [7:0] CMD_INIT_FIELD_ON  = 8'h01;
   localparam logic [7:0] CMD_RESP_FIELD_ON  = 8'h02;
   localparam logic [7:0] CMD_RESP_FIELD_N0  = 8'h03;
   localparam logic [7:0] CMD_GO_NORMAL      = 8'h04;
   localparam logic [7:0] CMD_ANALOG_PRESET  = 8'h05;
   typedef enum logic [1:0] {ST_IDLE, ST_AVOID, ST_GUARD} nfca_state_t;
   // ------------------------------------------------------------
   // timing
   // ------------------------------------------------------------
   localparam longint CLK_HZ          = 20_000_000;
   localparam longint FC_HZ           = 13_560_000;
   localparam int     INITIAL_DELAY_FC = 4096;
   localparam int     RF_WAIT_UNIT_FC  = 512;
   localparam int     INITIAL_GUARD_MS = 5;
   localparam int     ACTIVE_DELAY_FC  = 768;
   localparam int     ACTIVE_GUARD_FC  = 1024;
   function automatic int fc_cyc(input int n);
      fc_cyc = int'((longint'(n) * CLK_HZ + FC_HZ - 1) / FC_HZ);
   endfunction
   localparam int INITIAL_GUARD_CYC = int'(longint'(INITIAL_GUARD_MS) * CLK_HZ / 1000) + 1;
   localparam int INITIAL_DELAY_CYC = fc_cyc(INITIAL_DELAY_FC);
   localparam int RF_WAIT_UNIT_CYC  = fc_cyc(RF_WAIT_UNIT_FC);
   localparam int ACTIVE_DELAY_CYC  = fc_cyc(ACTIVE_DELAY_FC);
   localparam int ACTIVE_GUARD_CYC  = fc_cyc(ACTIVE_GUARD_FC);
endpackage

// [sim/nfca_host_model.sv]
// host model: apb master issuing register accesses and direct commands
`timescale 1ns/1ps
`default_nettype none
module nfca_host_model (
   input  wire logic        pclk,
   input  wire logic [31:0] prdata,
   input  wire logic        pready,
   input  wire logic        pslverr,
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic [7:0]       paddr,
   output logic [31:0]      pwdata
);
   initial
   begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
   end
   // ------------------------------------------------------------
   // one transfer: setup, access until pready, then release
   // ------------------------------------------------------------
   // callers repeat field on after a collision, preset only outside stream modes
   task automatic xfer(input logic w, input logic [5:0] idx, input logic [7:0] d,
                       output logic [31:0] r, output logic e);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= {idx, 2'b00};
      pwdata <= {24'h000000, d};
      @(posedge pclk);
      penable <= 1'b1;
      do
      begin
         @(posedge pclk);
      end
      while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      paddr <= ~paddr;
      pwdata <= ~pwdata;
   endtask
endmodule // nfca_host_model
`default_nettype wire

// [sim/tb_nfca_field_on.sv]
// testbench: field on sequencing, go normal and analog preset through apb
`timescale 1ns/1ps
`default_nettype none
module tb_nfca_field_on;
   import nfca_pkg::*;
   localparam int IDT  = 20;
   localparam int IRFG = 30;
   localparam int ADT  = int'((64'd768 * 64'd20000000 + 64'd13559999) / 64'd13560000);
   localparam int ARFG = int'((64'd1024 * 64'd20000000 + 64'd13559999) / 64'd13560000);
   localparam int RWU  = int'((64'd512 * 64'd20000000 + 64'd13559999) / 64'd13560000);
   logic        pclk = 1'b0;
   logic        presetn;
   logic        psel, penable, pwrite, pready, pslverr, tx_enable, osc_f, osc_a, e;
   logic [7:0]  paddr, rf, brd;
   logic [31:0] pwdata, prdata, r;
   int          n_mismatch = 0;
   int          check_count = 0;
   int          cyc = 0;
   int          i;
   always #25 pclk = ~pclk;
   always @(posedge pclk) cyc <= cyc + 1;
   nfca_field_on #(.IDT_CYC(IDT), .IRFG_CYC(IRFG)) nfca_field_on_inst (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .rf_field_inputs_level(rf), .osc_freq_stable(osc_f), .osc_ampl_stable(osc_a),
      .bit_rate_detected(brd), .tx_enable(tx_enable));
   nfca_host_model host_model_inst (
      .pclk(pclk), .prdata(prdata), .pready(pready), .pslverr(pslverr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("unexpected %s: expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic wr(input logic [5:0] idx, input logic [7:0] d);
      logic [31:0] q;
      logic        x;
      host_model_inst.xfer(1'b1, idx, d, q, x);
   endtask
   task automatic rdc(input string name, input logic [5:0] idx, input logic [31:0] exp);
      logic [31:0] q;
      logic        x;
      host_model_inst.xfer(1'b0, idx, 8'h00, q, x);
      check(name, q, exp);
   endtask
   task automatic field_on(input logic [7:0] cmd, input int dlo, input int dhi, input int glo);
      int          t0;
      int          t1;
      logic [31:0] q;
      logic        x;
      wr(IDX_OPERATION_CONTROL, 8'h80);
      wr(IDX_COMMAND, cmd);
      t0 = cyc;
      while (tx_enable !== 1'b1 && cyc - t0 < 6000) @(posedge pclk);
      t1 = cyc;
      check("tx delay", 32'(t1 - t0 >= dlo && t1 - t0 <= dhi), 32'h1);
      q = 32'h0;
      while (q[FLG_CAT_BIT] !== 1'b1 && cyc - t1 < 6000) host_model_inst.xfer(1'b0, IDX_EVENT_FLAGS, 8'h00, q, x);
      check("guard time", 32'(cyc - t1 >= glo && cyc - t1 <= glo + 8), 32'h1);
      check("done flags", q, 32'h1);
      check("tx on", {31'h0, tx_enable}, 32'h1);
   endtask
   task automatic summarize;
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // ------------------------------------------------------------
   // tests
   // ------------------------------------------------------------
   initial
   begin
      presetn = 1'b0;
      rf = 8'h00;
      osc_f = 1'b0;
      osc_a = 1'b0;
      brd = 8'h00;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      rdc("opc reset", IDX_OPERATION_CONTROL, 32'h0);
      rdc("type a reset", IDX_TYPE_A_NFC106_SETTINGS, 32'h0);
      rdc("aux reset", IDX_AUXILIARY_DEFINITION, 32'h0);
      rdc("threshold reset", IDX_FIELD_THRESHOLD, 32'h10);
      host_model_inst.xfer(1'b0, 6'h3F, 8'h00, r, e);
      check("unmapped error", {31'h0, e}, 32'h1);
      check("ready", {31'h0, pready}, 32'h1);
      $display("test reset values done");
      for (i = 0; i < 3; i++)
      begin
         @(posedge pclk);
         osc_f <= (i != 0);
         osc_a <= (i != 1);
         wr(IDX_OPERATION_CONTROL, (i == 2) ? 8'h00 : 8'h80);
         repeat (3) @(posedge pclk);
         wr(IDX_COMMAND, CMD_INIT_FIELD_ON);
         repeat (4) @(posedge pclk);
         rdc("refused status", IDX_SEQ_STATUS, 32'h0);
         rdc("refused flags", IDX_EVENT_FLAGS, 32'h0);
         check("refused tx", {31'h0, tx_enable}, 32'h0);
      end
      $display("test refused field on done");
      @(posedge pclk);
      rf <= 8'h10;
      wr(IDX_AUXILIARY_DEFINITION, 8'h03);
      wr(IDX_OPERATION_CONTROL, 8'h80);
      wr(IDX_COMMAND, CMD_RESP_FIELD_N0);
      repeat (6) @(posedge pclk);
      rdc("collision flags", IDX_EVENT_FLAGS, 32'h2);
      check("collision tx", {31'h0, tx_enable}, 32'h0);
      rdc("collision status", IDX_SEQ_STATUS, 32'h0);
      rdc("flags cleared", IDX_EVENT_FLAGS, 32'h0);
      @(posedge pclk);
      rf <= 8'h0F;
      repeat (2) @(posedge pclk);
      field_on(CMD_RESP_FIELD_N0, ADT, ADT + 4, ARFG);
      field_on(CMD_INIT_FIELD_ON, IDT, IDT + 3 * RWU + 4, IRFG);
      wr(IDX_AUXILIARY_DEFINITION, 8'h01);
      field_on(CMD_RESP_FIELD_ON, ADT, ADT + RWU + 4, ARFG);
      $display("test field on done");
      wr(IDX_MODE_DEFINITION, 8'h80);
      @(posedge pclk);
      brd <= 8'h20;
      wr(IDX_COMMAND, CMD_GO_NORMAL);
      rdc("normal mode", IDX_MODE_DEFINITION, 32'h90);
      rdc("copied rate", IDX_BIT_RATE_DEFINITION, 32'h20);
      rdc("am select", IDX_AUXILIARY_DEFINITION, 32'h21);
      wr(IDX_MODE_DEFINITION, 8'h80);
      @(posedge pclk);
      brd <= 8'h00;
      wr(IDX_COMMAND, CMD_GO_NORMAL);
      rdc("copied rate 106", IDX_BIT_RATE_DEFINITION, 32'h00);
      rdc("ook select", IDX_AUXILIARY_DEFINITION, 32'h01);
      $display("test go normal done");
      rdc("opc tx on", IDX_OPERATION_CONTROL, 32'h88);
      wr(IDX_MODE_DEFINITION, 8'h10);
      wr(IDX_COMMAND, CMD_ANALOG_PRESET);
      rdc("preset opc init", IDX_OPERATION_CONTROL, 32'hA0);
      check("preset tx off", {31'h0, tx_enable}, 32'h0);
      rdc("start byte", IDX_TYPE_A_NFC106_SETTINGS, 32'h20);
      rdc("preset aux init", IDX_AUXILIARY_DEFINITION, 32'h11);
      wr(IDX_MODE_DEFINITION, 8'h90);
      wr(IDX_BIT_RATE_DEFINITION, 8'h10);
      wr(IDX_OPERATION_CONTROL, 8'h88);
      wr(IDX_COMMAND, CMD_ANALOG_PRESET);
      rdc("preset opc target", IDX_OPERATION_CONTROL, 32'hA0);
      rdc("preset aux target", IDX_AUXILIARY_DEFINITION, 32'h31);
      wr(IDX_MODE_DEFINITION, 8'h80);
      wr(IDX_OPERATION_CONTROL, 8'h88);
      wr(IDX_COMMAND, CMD_ANALOG_PRESET);
      rdc("preset opc brdet", IDX_OPERATION_CONTROL, 32'h80);
      rdc("preset aux brdet", IDX_AUXILIARY_DEFINITION, 32'h21);
      rdc("start byte off", IDX_TYPE_A_NFC106_SETTINGS, 32'h00);
      $display("test analog preset done");
      summarize();
   end
   initial
   begin
      #(50 * 60000);
      n_mismatch++;
      summarize();
   end
endmodule // tb_nfca_field_on
`default_nettype wire
